// ==== design/dnps_chg.sv ====
`timescale 1ns/1ps
`default_nettype none
// Times the on-the-fly channel change blind spot
module dnps_chg #(
  parameter int CYC = 3400
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  output logic busy
);
  logic [15:0] cnt_q, cnt_d;
  logic busy_q, busy_d;

  // Countdown next state
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (start) begin
      cnt_d = 16'(CYC - 1);
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == 16'h0000) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
  end

  // Countdown registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
endmodule
`default_nettype wire

// ==== design/dnps_pkg.sv ====
`default_nettype none
package dnps_pkg;
  // Register word offsets on the plain register port
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_DWELL = 5'h01;
  localparam logic [4:0] ADDR_STATUS = 5'h02;
  localparam logic [4:0] ADDR_REMAIN = 5'h03;
  localparam logic [4:0] ADDR_CH_INT0 = 5'h04;
  localparam logic [4:0] ADDR_CH_FRAC0 = 5'h05;
  localparam logic [4:0] ADDR_NETID0 = 5'h06;
  localparam logic [4:0] ADDR_SHORT0 = 5'h07;
  localparam logic [4:0] ADDR_LONG0_LO = 5'h08;
  localparam logic [4:0] ADDR_LONG0_HI = 5'h09;
  localparam logic [4:0] ADDR_CH_INT1 = 5'h0C;
  localparam logic [4:0] ADDR_CH_FRAC1 = 5'h0D;
  localparam logic [4:0] ADDR_NETID1 = 5'h0E;
  localparam logic [4:0] ADDR_SHORT1 = 5'h0F;
  localparam logic [4:0] ADDR_LONG1_LO = 5'h10;
  localparam logic [4:0] ADDR_LONG1_HI = 5'h11;
  // Control register bit positions
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_COORD0_BIT = 2;
  localparam int CTRL_COORD1_BIT = 3;
  // Status register bit positions
  localparam int STAT_CUR_BIT = 0;
  localparam int STAT_CHG_BIT = 1;
  localparam int STAT_PEND_BIT = 2;
  // Widths
  localparam int DATA_W = 32;
  localparam int DWELL_W = 24;
  localparam int CH_INT_W = 8;
  localparam int CH_FRAC_W = 16;
  // Timing: dwell tick period and on-the-fly channel change
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int CHG_US = 68;
  localparam int CHG_CYC = CHG_US * CLK_MHZ;
  // Reset values
  localparam logic [DWELL_W-1:0] DWELL_RST = 24'h000000;
  localparam logic [CH_INT_W-1:0] CH_INT_RST = 8'h00;
  localparam logic [CH_FRAC_W-1:0] CH_FRAC_RST = 16'h0000;
  // Sequence manager states seen by this block
  typedef enum logic [2:0] {
    DNPS_SQ_IDLE,
    DNPS_SQ_WARMUP,
    DNPS_SQ_RX_PRE,
    DNPS_SQ_RX_PKT,
    DNPS_SQ_OTHER
  } dnps_seq_t;
endpackage
`default_nettype wire

// ==== design/dnps_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
// Free-running one-cycle enable at the dwell tick rate
module dnps_tick #(
  parameter int DIV = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Tick out
  output logic tick
);
  logic [15:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  // Divider next state
  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 16'h0001;
    if (cnt_q == 16'(DIV - 1)) begin
      cnt_d = 16'h0000;
      tick_d = 1'b1;
    end
  end

  // Divider registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// ==== design/dnps_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dnps_top
  import dnps_pkg::*;
#(
  parameter int DWELL_BITS = dnps_pkg::DWELL_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [dnps_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dnps_pkg::DATA_W-1:0] reg_rdata,
  // Sequence manager state
  input wire dnps_pkg::dnps_seq_t seq_state,
  input wire logic seq_rx_only,
  input wire logic rx_pkt_fail,
  // Active network parameters to radio
  output logic cur_network,
  output logic [dnps_pkg::CH_INT_W-1:0] channel_integer,
  output logic [dnps_pkg::CH_FRAC_W-1:0] channel_fraction,
  output logic [15:0] network_id,
  output logic [15:0] short_address,
  output logic [63:0] long_address,
  output logic coordinator_flag,
  output logic chg_active,
  output logic pll_retune
);
  import dnps_pkg::*;

  // Parameter sets, index is network number
  logic [CH_INT_W-1:0] ch_int_q [2], ch_int_d [2];
  logic [CH_FRAC_W-1:0] ch_frac_q [2], ch_frac_d [2];
  logic [15:0] netid_q [2], netid_d [2];
  logic [15:0] short_q [2], short_d [2];
  logic [63:0] long_q [2], long_d [2];
  // Control and dwell timer state
  logic [1:0] coord_q, coord_d;
  logic select_q, select_d;
  logic auto_q, auto_d;
  logic [DWELL_BITS-1:0] dwell_set_q, dwell_set_d;
  logic [DWELL_BITS-1:0] remain_q, remain_d;
  logic armed_q, armed_d;
  logic pending_q, pending_d;
  logic cur_q, cur_d;
  logic held_q, held_d;
  logic retune_q, retune_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic tick;
  logic chg_busy;
  logic expire;
  logic switch_now;
  logic idle;
  logic in_search;
  logic counting;

  // Dwell tick enable
  dnps_tick #(.DIV(TICK_CYC)) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // Blind spot after each retune; a switch at idle needs no on-the-fly change,
  // since the next warm-up tunes the new channel anyway
  dnps_chg #(.CYC(CHG_CYC)) u_chg (
    .clk(clk),
    .arst_n(arst_n),
    .start(retune_d),
    .busy(chg_busy)
  );

  // Sequence phase decode
  assign idle = (seq_state == DNPS_SQ_IDLE);
  // Only a receive-only sequence may switch during preamble search
  assign in_search = (seq_state == DNPS_SQ_RX_PRE) && seq_rx_only;
  // Timer runs only with auto on, armed, and a sequence underway
  assign counting = auto_q && armed_q && !idle;

  // Per-network register writes
  for (genvar n = 0; n < 2; n++) begin : g_net
    logic [4:0] base;
    // Base offset of this network's block
    assign base = (n == 0) ? ADDR_CH_INT0 : ADDR_CH_INT1;
    // Field decode at this network's base offset
    always_comb begin
      ch_int_d[n] = ch_int_q[n];
      ch_frac_d[n] = ch_frac_q[n];
      netid_d[n] = netid_q[n];
      short_d[n] = short_q[n];
      long_d[n] = long_q[n];
      if (reg_wr) begin
        if (reg_addr == base) begin
          ch_int_d[n] = reg_wdata[CH_INT_W-1:0];
        end else if (reg_addr == base + 5'h01) begin
          ch_frac_d[n] = reg_wdata[CH_FRAC_W-1:0];
        end else if (reg_addr == base + 5'h02) begin
          netid_d[n] = reg_wdata[15:0];
        end else if (reg_addr == base + 5'h03) begin
          short_d[n] = reg_wdata[15:0];
        end else if (reg_addr == base + 5'h04) begin
          long_d[n][31:0] = reg_wdata;
        end else if (reg_addr == base + 5'h05) begin
          long_d[n][63:32] = reg_wdata;
        end
      end
    end
    // Parameter set registers
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ch_int_q[n] <= CH_INT_RST;
        ch_frac_q[n] <= CH_FRAC_RST;
        netid_q[n] <= 16'h0000;
        short_q[n] <= 16'h0000;
        long_q[n] <= 64'h0000000000000000;
      end else begin
        ch_int_q[n] <= ch_int_d[n];
        ch_frac_q[n] <= ch_frac_d[n];
        netid_q[n] <= netid_d[n];
        short_q[n] <= short_d[n];
        long_q[n] <= long_d[n];
      end
    end
  end

  // Expiry only seen while counting, so a frozen zero never refires; no
  // expiry at idle, so alternation ends once the sequence has ended
  assign expire = counting && tick && (remain_q == '0) && !pending_q;
  // Switch may happen now: in receive-only preamble search, or back at idle
  assign switch_now = auto_q && (expire || pending_q) && !chg_busy
    && (in_search || idle);

  // Control, dwell timer and current network
  always_comb begin
    select_d = select_q;
    auto_d = auto_q;
    coord_d = coord_q;
    dwell_set_d = dwell_set_q;
    remain_d = remain_q;
    armed_d = armed_q;
    pending_d = pending_q;
    cur_d = cur_q;
    held_d = held_q;
    retune_d = 1'b0;
    // Timer counts down per tick only with auto enabled and armed
    if (counting && tick && remain_q != '0) begin
      remain_d = remain_q - DWELL_BITS'(1);
    end
    // Idle-time reload waits for warm-up to arm the timer
    if (!armed_q && seq_state == DNPS_SQ_WARMUP) begin
      armed_d = 1'b1;
    end
    if (expire) begin
      pending_d = 1'b1;
    end
    if (switch_now) begin
      cur_d = ~cur_q;
      pending_d = 1'b0;
      remain_d = dwell_set_q;
      retune_d = !idle;
    end else if (auto_q && pending_q && seq_state == DNPS_SQ_RX_PKT && rx_pkt_fail) begin
      // Bad packet after deferral: toggle and go back to search
      cur_d = ~cur_q;
      pending_d = 1'b0;
      remain_d = dwell_set_q;
      retune_d = 1'b1;
    end
    // Manual mode follows the select bit; auto keeps its own network
    if (!auto_q) begin
      cur_d = select_q;
    end
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      select_d = reg_wdata[CTRL_SEL_BIT];
      auto_d = reg_wdata[CTRL_AUTO_BIT];
      coord_d = {reg_wdata[CTRL_COORD1_BIT], reg_wdata[CTRL_COORD0_BIT]};
      // Leaving auto freezes timer and held network. Entering with an armed
      // timer resumes the captured network; otherwise start on select.
      if (!auto_q && reg_wdata[CTRL_AUTO_BIT]) begin
        if (armed_q) begin
          cur_d = held_q;
        end else begin
          cur_d = reg_wdata[CTRL_SEL_BIT];
        end
      end
    end
    if (reg_wr && reg_addr == ADDR_DWELL) begin
      dwell_set_d = reg_wdata[DWELL_BITS-1:0];
      remain_d = reg_wdata[DWELL_BITS-1:0];
      armed_d = !idle;
      pending_d = 1'b0;
      cur_d = select_q;
      // Restart takes the select network, with no retune
      retune_d = 1'b0;
    end
    // Capture the serviced network while auto runs, for resume
    if (auto_q) begin
      held_d = cur_d;
    end
  end

  // Control and timer registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      select_q <= 1'b0;
      auto_q <= 1'b0;
      coord_q <= 2'h0;
      dwell_set_q <= '0;
      remain_q <= '0;
      armed_q <= 1'b0;
      pending_q <= 1'b0;
      cur_q <= 1'b0;
      held_q <= 1'b0;
      retune_q <= 1'b0;
    end else begin
      select_q <= select_d;
      auto_q <= auto_d;
      coord_q <= coord_d;
      dwell_set_q <= dwell_set_d;
      remain_q <= remain_d;
      armed_q <= armed_d;
      pending_q <= pending_d;
      cur_q <= cur_d;
      held_q <= held_d;
      retune_q <= retune_d;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      if (reg_addr == ADDR_CTRL) begin
        rdata_d[CTRL_SEL_BIT] = select_q;
        rdata_d[CTRL_AUTO_BIT] = auto_q;
        rdata_d[CTRL_COORD0_BIT] = coord_q[0];
        rdata_d[CTRL_COORD1_BIT] = coord_q[1];
      end else if (reg_addr == ADDR_DWELL) begin
        rdata_d[DWELL_BITS-1:0] = dwell_set_q;
      end else if (reg_addr == ADDR_STATUS) begin
        rdata_d[STAT_CUR_BIT] = cur_q;
        rdata_d[STAT_CHG_BIT] = chg_busy;
        rdata_d[STAT_PEND_BIT] = pending_q;
      end else if (reg_addr == ADDR_REMAIN) begin
        rdata_d[DWELL_BITS-1:0] = remain_q;
      end else if (reg_addr == ADDR_CH_INT0 || reg_addr == ADDR_CH_INT1) begin
        rdata_d[CH_INT_W-1:0] = ch_int_q[reg_addr == ADDR_CH_INT1];
      end else if (reg_addr == ADDR_CH_FRAC0 || reg_addr == ADDR_CH_FRAC1) begin
        rdata_d[CH_FRAC_W-1:0] = ch_frac_q[reg_addr == ADDR_CH_FRAC1];
      end else if (reg_addr == ADDR_NETID0 || reg_addr == ADDR_NETID1) begin
        rdata_d[15:0] = netid_q[reg_addr == ADDR_NETID1];
      end else if (reg_addr == ADDR_SHORT0 || reg_addr == ADDR_SHORT1) begin
        rdata_d[15:0] = short_q[reg_addr == ADDR_SHORT1];
      end else if (reg_addr == ADDR_LONG0_LO || reg_addr == ADDR_LONG1_LO) begin
        rdata_d = long_q[reg_addr == ADDR_LONG1_LO][31:0];
      end else if (reg_addr == ADDR_LONG0_HI || reg_addr == ADDR_LONG1_HI) begin
        rdata_d = long_q[reg_addr == ADDR_LONG1_HI][63:32];
      end
    end
  end

  // Output state; selected set drives tuning and filtering
  logic [CH_INT_W-1:0] o_int_q, o_int_d;
  logic [CH_FRAC_W-1:0] o_frac_q, o_frac_d;
  logic [15:0] o_id_q, o_id_d;
  logic [15:0] o_short_q, o_short_d;
  logic [63:0] o_long_q, o_long_d;
  logic o_coord_q, o_coord_d;
  logic o_chg_q, o_chg_d;

  // Pick the serviced set; outputs lag cur_network by one cycle
  always_comb begin
    o_int_d = ch_int_q[cur_q];
    o_frac_d = ch_frac_q[cur_q];
    o_id_d = netid_q[cur_q];
    o_short_d = short_q[cur_q];
    o_long_d = long_q[cur_q];
    o_coord_d = coord_q[cur_q];
    o_chg_d = chg_busy;
  end

  // Read data and output registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
      o_int_q <= CH_INT_RST;
      o_frac_q <= CH_FRAC_RST;
      o_id_q <= 16'h0000;
      o_short_q <= 16'h0000;
      o_long_q <= 64'h0000000000000000;
      o_coord_q <= 1'b0;
      o_chg_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      o_int_q <= o_int_d;
      o_frac_q <= o_frac_d;
      o_id_q <= o_id_d;
      o_short_q <= o_short_d;
      o_long_q <= o_long_d;
      o_coord_q <= o_coord_d;
      o_chg_q <= o_chg_d;
    end
  end

  // Ports straight from flip-flops
  assign reg_rdata = rdata_q;
  assign cur_network = cur_q;
  assign channel_integer = o_int_q;
  assign channel_fraction = o_frac_q;
  assign network_id = o_id_q;
  assign short_address = o_short_q;
  assign long_address = o_long_q;
  assign coordinator_flag = o_coord_q;
  assign chg_active = o_chg_q;
  assign pll_retune = retune_q;
endmodule
`default_nettype wire

// ==== sim/dnps_top_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dnps_top_chk
  import dnps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Observed ports
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [dnps_pkg::DATA_W-1:0] reg_rdata,
  input wire dnps_pkg::dnps_seq_t seq_state,
  input wire logic rx_pkt_fail,
  input wire logic cur_network,
  input wire logic chg_active,
  input wire logic pll_retune
);
  int chg_len_q;
  int chg_len_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Blind spot length, too long for a repetition
  always_comb begin
    chg_len_d = chg_active ? chg_len_q + 1 : 0;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chg_len_q <= 0;
    end else begin
      chg_len_q <= chg_len_d;
    end
  end
  a_rdata_only_read: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside read slot");
  a_retune_one_pulse: assert property (pll_retune |=> !pll_retune)
    else $error("retune longer than one cycle");
  a_retune_with_switch: assert property (pll_retune |-> cur_network != $past(cur_network))
    else $error("retune without network switch");
  a_retune_blind_start: assert property (pll_retune |-> ##[1:2] chg_active)
    else $error("no blind spot after retune");
  a_blind_length: assert property ($fell(chg_active) |->
    chg_len_q >= CHG_CYC - 1 && chg_len_q <= CHG_CYC + 1)
    else $error("blind spot length wrong");
  a_blind_no_switch: assert property (chg_active && $past(chg_active) |->
    cur_network == $past(cur_network))
    else $error("switch inside blind spot");
  a_packet_defers: assert property (seq_state == DNPS_SQ_RX_PKT && !rx_pkt_fail && !reg_wr
    |=> $stable(cur_network))
    else $error("switch during packet");
  a_busy_defers: assert property (seq_state inside {DNPS_SQ_WARMUP, DNPS_SQ_OTHER} && !reg_wr
    |=> $stable(cur_network))
    else $error("switch outside preamble search");
  a_idle_no_retune: assert property (seq_state == DNPS_SQ_IDLE |=> !pll_retune)
    else $error("retune from idle");
endmodule
bind dnps_top dnps_top_chk u_chk (.clk(clk), .arst_n(arst_n), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata), .seq_state(seq_state), .rx_pkt_fail(rx_pkt_fail),
  .cur_network(cur_network), .chg_active(chg_active), .pll_retune(pll_retune));
`default_nettype wire

// ==== sim/dnps_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dnps_top_tb;
  import dnps_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  dnps_seq_t seq_state = DNPS_SQ_IDLE;
  logic seq_rx_only = 1'b0;
  logic rx_pkt_fail = 1'b0;
  logic cur_network, coordinator_flag, chg_active, pll_retune;
  logic [CH_INT_W-1:0] channel_integer;
  logic [CH_FRAC_W-1:0] channel_fraction;
  logic [15:0] network_id, short_address;
  logic [63:0] long_address;
  logic [31:0] lfsr_q = 32'hEC6DC171;
  logic [31:0] mem [32];
  logic [DATA_W-1:0] rv, r1;
  int err_total = 0;
  int total_checks = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  dnps_top u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_state(seq_state),
    .seq_rx_only(seq_rx_only), .rx_pkt_fail(rx_pkt_fail), .cur_network(cur_network),
    .channel_integer(channel_integer), .channel_fraction(channel_fraction),
    .network_id(network_id), .short_address(short_address), .long_address(long_address),
    .coordinator_flag(coordinator_flag), .chg_active(chg_active), .pll_retune(pll_retune));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // Field width per map slot; holes keep nothing
  function automatic logic [31:0] fmask(input int a);
    if (a > 9 && a < 12) return 32'h0;
    case (a % 8)
      4: return 32'h000000FF;
      5, 6, 7: return 32'h0000FFFF;
      default: return 32'hFFFFFFFF;
    endcase
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input int a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a[4:0];
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input int a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a[4:0];
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Coordinator on net0 only, so the flag tells the sets apart
  task automatic ctrl(input logic s, input logic au);
    wr(ADDR_CTRL, {28'h0, 1'b0, 1'b1, au, s});
  endtask
  task automatic seq(input dnps_seq_t st, input logic ro);
    @(posedge clk);
    seq_state <= st;
    seq_rx_only <= ro;
  endtask
  // Bounded wait: 0 for a retune pulse, 1 for the blind spot to end
  task automatic wait_for(input int which, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (n < lim && (which == 0 ? pll_retune !== 1'b1 : chg_active !== 1'b0));
    if (n >= lim) begin
      err_total++;
      $display("mismatch at %0t: wait limit", $time);
    end
  endtask
  task automatic chk_net(input int n);
    int b;
    b = n ? 12 : 4;
    repeat (3) @(posedge clk);
    #1 chk(cur_network, n);
    chk(coordinator_flag, n == 0);
    chk(channel_integer, mem[b]);
    chk(channel_fraction, mem[b+1]);
    chk(network_id, mem[b+2]);
    chk(short_address, mem[b+3]);
    chk(long_address, {mem[b+5], mem[b+4]});
    rd(ADDR_STATUS, rv);
    chk(rv[STAT_CUR_BIT], n);
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 32; a++) begin
      rd(a, rv);
      chk(rv, 0);
    end
    // Random parameter sets, holes included
    for (int a = 4; a < 18; a++) begin
      lfsr_q = lfsr_next(lfsr_q);
      mem[a] = lfsr_q & fmask(a);
      wr(a, lfsr_q);
    end
    for (int a = 4; a < 18; a++) begin
      rd(a, rv);
      chk(rv, mem[a]);
    end
    for (int s = 0; s < 2; s++) begin
      ctrl(s[0], 1'b0);
      chk_net(s);
    end
    // Auto mode: select first, then dwell
    ctrl(1'b1, 1'b1);
    wr(ADDR_DWELL, 3);
    repeat (200) @(posedge clk);
    rd(ADDR_REMAIN, rv);
    chk(rv, 3);
    seq(DNPS_SQ_WARMUP, 1'b1);
    seq(DNPS_SQ_RX_PRE, 1'b1);
    chk_net(1);
    for (int k = 0; k < 2; k++) begin
      wait_for(0, 5000);
      chk_net(k);
      chk(chg_active, 1);
    end
    // Expiry inside a packet waits for its outcome
    seq(DNPS_SQ_RX_PKT, 1'b1);
    wait_for(1, 5000);
    repeat (500) @(posedge clk);
    rd(ADDR_STATUS, rv);
    chk(rv[STAT_PEND_BIT], 1);
    chk(cur_network, 1);
    @(posedge clk);
    rx_pkt_fail <= 1'b1;
    @(posedge clk);
    rx_pkt_fail <= 1'b0;
    chk_net(0);
    seq(DNPS_SQ_OTHER, 1'b0);
    wait_for(1, 5000);
    repeat (500) @(posedge clk);
    seq(DNPS_SQ_RX_PRE, 1'b0);
    repeat (20) @(posedge clk);
    #1 chk(cur_network, 0);
    seq(DNPS_SQ_IDLE, 1'b0);
    chk_net(1);
    // Sequence over: no further alternation at idle
    repeat (300) @(posedge clk);
    #1 chk(cur_network, 1);
    // Freeze and resume
    wr(ADDR_DWELL, 40);
    rd(ADDR_REMAIN, rv);
    chk(rv, 40);
    seq(DNPS_SQ_WARMUP, 1'b1);
    repeat (600) @(posedge clk);
    seq(DNPS_SQ_IDLE, 1'b1);
    ctrl(1'b0, 1'b0);
    chk_net(0);
    rd(ADDR_REMAIN, r1);
    repeat (300) @(posedge clk);
    rd(ADDR_REMAIN, rv);
    chk(rv, r1);
    ctrl(1'b0, 1'b1);
    chk_net(1);
    seq(DNPS_SQ_WARMUP, 1'b1);
    repeat (200) @(posedge clk);
    rd(ADDR_REMAIN, rv);
    chk(rv < r1 && rv + 6 > r1, 1);
    final_report();
  end
endmodule
`default_nettype wire
